// ---- hdl/pic_pkg.sv ----
// Purpose: constants for the prioritised interrupt controller
// Assumes: Avalon-MM word addressing, 16-bit registers in the low half of 32-bit data
// Notes: the rule summary below describes the controller's behaviour
//
// Summary of operation
// - The controller exposes twenty registers: two global controls, flag, enable, priority and vector banks, status, core and three event registers.
// - Each source owns one flag bit that hardware sets and only a software write clears.
// - Each source has its own enable bit that permits or blocks it independently.
// - Each source has a programmable 3-bit priority field selecting one of eight levels.
// - The winning request latches a 7-bit vector number and 4-bit level into the pending-vector register.
// - The latched level equals the programmed priority of the pending source.
// - Bit positions follow vector order, source 0 being vector 8 at flag bit 0 and priority bits 2:0.
// - The first global control register holds the nesting-disable bit and the trap flags.
// - The second global control register sets external-request edge polarity and stores an alternate table bit that has no effect.
// - Status word bits 7:5 report and, when written, change the low three priority bits.
// - While nesting-disable (bit 15) is set the status priority bits ignore writes.
// - Priority bit 3 in core control bit 3 cannot be set by software and resets to 0.
// - The processor level is priority bit 3 above the three status bits, giving 0 to 15.
// - Low bits equal to 111 block all user interrupts.
// - Priority bit 3 set blocks all user interrupts.
package pic_pkg;
   localparam int PIC_NSRC = 32;
   localparam int PIC_NPRI = 8;
   localparam logic [6:0] PIC_VEC_BASE = 7'h08;
   // word indices on the bus
   localparam logic [4:0] PIC_A_GCTL1 = 5'h00;
   localparam logic [4:0] PIC_A_GCTL2 = 5'h01;
   localparam logic [4:0] PIC_A_FLAG0 = 5'h02;
   localparam logic [4:0] PIC_A_EN0 = 5'h04;
   localparam logic [4:0] PIC_A_PRI0 = 5'h06;
   localparam logic [4:0] PIC_A_VEC = 5'h0e;
   localparam logic [4:0] PIC_A_SR = 5'h10;
   localparam logic [4:0] PIC_A_CORE = 5'h11;
   localparam logic [4:0] PIC_A_IRQST = 5'h12;
   localparam logic [4:0] PIC_A_IRQEN = 5'h13;
   localparam logic [4:0] PIC_A_IRQCLR = 5'h14;
   // field positions
   localparam int PIC_NESTING_DISABLE_BIT = 15;
   localparam int PIC_ALTIVT_BIT = 15;
   localparam int PIC_IPL_LSB = 5;
   localparam int PIC_CPU_PRIORITY_TOP_BIT_BIT = 3;
   localparam int PIC_NTRAP = 5;
   localparam int PIC_NEXT = 3;
   localparam logic [15:0] PIC_RST_WORD = 16'h0000;
   localparam logic [31:0] PIC_UNMAPPED = 32'hdead_0000;
endpackage

// ---- hdl/pic_ctrl.sv ----
// Purpose: prioritised interrupt controller with Avalon-MM register slave
// Assumes: single clock clk_sys at 40 MHz, sources synchronous except ext_req
// Notes: one-cycle bus answer, trap requests never masked by processor level
`timescale 1ns/1ps
module pic_ctrl
   import pic_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [pic_pkg::PIC_NSRC-1:0] src_req,
   input wire logic [pic_pkg::PIC_NEXT-1:0] ext_req,
   input wire logic [pic_pkg::PIC_NTRAP-1:0] trap_req,
   input wire logic cpu_ack,
   output logic cpu_irq,
   output logic cpu_trap,
   output logic [6:0] pending_vector_number,
   output logic [3:0] pending_level,
   output logic irq
);
   import pic_pkg::*;

   logic [15:0] gctl1_q;
   logic [15:0] gctl2_q;
   logic [PIC_NSRC-1:0] flag_q;
   logic [PIC_NSRC-1:0] en_q;
   logic [2:0] pri_q [PIC_NSRC];
   logic [2:0] ipl_low_q;
   logic cpu_priority_top_bit_q;
   logic [6:0] vec_q;
   logic [3:0] lvl_q;
   logic req_q;
   logic [4:0] irq_st_q;
   logic [4:0] irq_en_q;
   logic [31:0] rdata_q;
   logic ack_q;
   // external pin stages and the agreed level per line
   logic [PIC_NEXT-1:0] ext_s1_q;
   logic [PIC_NEXT-1:0] ext_s2_q;
   logic [PIC_NEXT-1:0] ext_s3_q;
   logic [PIC_NEXT-1:0] ext_lvl_q;
   logic wr_lo;
   logic wr_hi;
   logic acc;

   ////////////////////////////////////////////////////////////////////////
   // bus slave: one wait cycle, answer on the second edge
   // the first cycle of any request always stalls, so the read
   // mux has a full cycle to settle before its value is registered
   // writes land only in the cycle with ack_q high, i.e. at the
   // edge where the master sees waitrequest low
   // limitation: a master that drops its request early loses it
   assign acc = (avs_read | avs_write) & ~ack_q;
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wr_lo = avs_write & ack_q & avs_byteenable[0];
   assign wr_hi = avs_write & ack_q & avs_byteenable[1];

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         ack_q <= 1'b0;
      else
         ack_q <= acc;
   end

   // byte-laned write of a 16-bit word
   // only lanes 0 and 1 matter; the upper half of the bus word is
   // ignored because every register here is 16 bits wide
   // a write with no lane enabled leaves the word untouched
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd, input logic lo,
                                         input logic hi);
      logic [15:0] r;
      r = old;
      if (lo)
         r[7:0] = wd[7:0];
      if (hi)
         r[15:8] = wd[15:8];
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // external request inputs: three stages, rising edge counted once stages agree, falling edge once stage two drops
   // stage one may go metastable, so only stage two reads it
   // the agreed level moves only when stages two and three match,
   // which filters a single-cycle glitch on the pin
   // trade-off: four cycles of latency from pin to flag on rising lines, three on falling lines
   logic [PIC_NEXT-1:0] ext_edge;
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_s1_q <= '0;
         ext_s2_q <= '0;
         ext_s3_q <= '0;
         ext_lvl_q <= '0;
      end
      else
      begin
         ext_s1_q <= ext_req;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
         for (int i = 0; i < PIC_NEXT; i++)
            if (ext_s2_q[i] == ext_s3_q[i])
               ext_lvl_q[i] <= ext_s3_q[i];
      end
   end

   // polarity per line from second global control, low bits: 1 = falling edge
   // for rising lines the edge is seen one cycle before the agreed level follows it, giving one set pulse;
   // falling lines set as soon as stage two drops, so even a one-cycle low glitch sets the flag
   // changing polarity while a pin is steady raises no flag
   always_comb
   begin
      for (int i = 0; i < PIC_NEXT; i++)
      begin
         if (gctl2_q[i])
            ext_edge[i] = ext_lvl_q[i] & ~(ext_s2_q[i] & ext_s3_q[i]);
         else
            ext_edge[i] = ~ext_lvl_q[i] & ext_s2_q[i] & ext_s3_q[i];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // set events: external lines on low flag bits, peripherals on all
   // a peripheral pulse and a pin edge on the same low bit merge
   // into one set; the flag cannot count repeated events
   logic [PIC_NSRC-1:0] set_ev;
   always_comb
   begin
      set_ev = src_req;
      set_ev[PIC_NEXT-1:0] = src_req[PIC_NEXT-1:0] | ext_edge;
   end

   // flags: set wins over a software clear in the same cycle
   // so an event racing a clear is never lost
   // one generate entry per source keeps bank, lane and bit
   // position as constants, leaving only the address compare
   // enables and priorities are plain read-write storage
   genvar g;
   generate
      for (g = 0; g < PIC_NSRC; g++)
      begin : g_src
         localparam logic [4:0] FA = PIC_A_FLAG0 + 5'(g / 16);
         localparam logic [4:0] EA = PIC_A_EN0 + 5'(g / 16);
         localparam logic [4:0] PA = PIC_A_PRI0 + 5'(g / 4);
         localparam int FB = g % 16;
         localparam int PB = (g % 4) * 4;
         always_ff @(posedge clk_sys or negedge rst_n)
         begin
            if (!rst_n)
            begin
               flag_q[g] <= 1'b0;
               en_q[g] <= 1'b0;
               pri_q[g] <= 3'h0;
            end
            else
            begin
               if (set_ev[g])
                  flag_q[g] <= 1'b1;
               else if (avs_address == FA && ((FB < 8) ? wr_lo : wr_hi))
                  flag_q[g] <= avs_writedata[FB];
               if (avs_address == EA && ((FB < 8) ? wr_lo : wr_hi))
                  en_q[g] <= avs_writedata[FB];
               if (avs_address == PA && ((PB < 8) ? wr_lo : wr_hi))
                  pri_q[g] <= avs_writedata[PB +: 3];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // global control, status word priority and core control top bit
   // trap flags in the first control word are sticky: a trap pulse
   // always sets, and a low-lane write may clear the rest
   // the second control word's low bits select pin edge polarity; the
   // alternate table select has no effect inside this block
   logic [PIC_NTRAP-1:0] trap_flags;
   assign trap_flags = gctl1_q[PIC_NTRAP:1];

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gctl1_q <= PIC_RST_WORD;
         gctl2_q <= PIC_RST_WORD;
      end
      else
      begin
         if (avs_address == PIC_A_GCTL1)
            gctl1_q <= merge(gctl1_q, avs_writedata, wr_lo, wr_hi);
         gctl1_q[PIC_NTRAP:1] <= (avs_address == PIC_A_GCTL1 && wr_lo) ?
            (avs_writedata[PIC_NTRAP:1] | trap_req) : (trap_flags | trap_req);
         if (avs_address == PIC_A_GCTL2)
            gctl2_q <= merge(gctl2_q, avs_writedata, wr_lo, wr_hi);
      end
   end

   // level change on accepted request; software writes only when nesting allowed
   // an acceptance beats a software write in the same cycle, as the
   // core has already committed to the new level
   // the top bit is only ever set by an accepted trap, and software
   // may only clear it, so user code cannot mask traps
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ipl_low_q <= 3'h0;
         cpu_priority_top_bit_q <= 1'b0;
      end
      else
      begin
         if (cpu_ack && req_q && !cpu_trap)
            ipl_low_q <= lvl_q[2:0];
         else if (avs_address == PIC_A_SR && wr_lo && !gctl1_q[PIC_NESTING_DISABLE_BIT])
            ipl_low_q <= avs_writedata[PIC_IPL_LSB +: 3];
         if (cpu_ack && cpu_trap)
            cpu_priority_top_bit_q <= 1'b1;
         else if (avs_address == PIC_A_CORE && wr_lo && !avs_writedata[PIC_CPU_PRIORITY_TOP_BIT_BIT])
            cpu_priority_top_bit_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // arbitration: highest priority above processor level, lowest index on ties
   // the scan runs from the top index down with a greater-or-equal
   // test, so a later, lower index takes every tie
   // a long combinational chain; fine at 40 MHz for 32 sources
   // level seven or the top bit blocks every user source outright
   logic [3:0] cpu_lvl;
   logic win_v;
   logic [4:0] win_i;
   logic [2:0] win_p;
   assign cpu_lvl = {cpu_priority_top_bit_q, ipl_low_q};

   always_comb
   begin
      win_v = 1'b0;
      win_i = 5'h0;
      win_p = 3'h0;
      for (int i = PIC_NSRC - 1; i >= 0; i--)
      begin
         if (flag_q[i] && en_q[i] && ({1'b0, pri_q[i]} > cpu_lvl)
             && (!win_v || pri_q[i] >= win_p))
         begin
            win_v = 1'b1;
            win_i = 5'(i);
            win_p = pri_q[i];
         end
      end
      if (cpu_priority_top_bit_q || ipl_low_q == 3'h7)
         win_v = 1'b0;
   end

   // latch vector and level of the winner
   // traps outrank every user source and report vector 0, level 15
   // the register keeps the last winner while nothing is pending,
   // so the core can still read what it accepted
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         vec_q <= 7'h00;
         lvl_q <= 4'h0;
         req_q <= 1'b0;
      end
      else
      begin
         req_q <= win_v | (|trap_flags);
         if (|trap_flags)
         begin
            vec_q <= 7'h00;
            lvl_q <= 4'hf;
         end
         else if (win_v)
         begin
            vec_q <= PIC_VEC_BASE + 7'(win_i);
            lvl_q <= {1'b0, win_p};
         end
      end
   end

   assign cpu_irq = req_q;
   assign cpu_trap = lvl_q[3];
   assign pending_vector_number = vec_q;
   assign pending_level = lvl_q;

   ////////////////////////////////////////////////////////////////////////
   // system interrupt: status sticky, enable masks, write-one-to-clear
   // events: bit 0 acceptance, 1 peripheral, 2 pin edge, 3 user
   // winner, 4 trap; bit 3 stays asserted while a winner stands,
   // so clearing it only sticks once the request goes away
   logic [4:0] ev;
   assign ev = {|trap_flags, win_v, |ext_edge, |src_req, cpu_ack};
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_st_q <= 5'h00;
         irq_en_q <= 5'h00;
      end
      else
      begin
         if (avs_address == PIC_A_IRQCLR && wr_lo)
            irq_st_q <= (irq_st_q & ~avs_writedata[4:0]) | ev; // set beats clear
         else
            irq_st_q <= irq_st_q | ev;
         if (avs_address == PIC_A_IRQEN && wr_lo)
            irq_en_q <= avs_writedata[4:0];
      end
   end
   assign irq = |(irq_st_q & irq_en_q);

   ////////////////////////////////////////////////////////////////////////
   // read mux, registered on the waiting cycle
   // unused indices inside the map read as zero; indices above the
   // last register read as a fixed marker so a stray access shows
   // priority words pack four 3-bit fields at nibble positions
   logic [15:0] rd;
   always_comb
   begin
      rd = 16'h0000;
      if (avs_address == PIC_A_GCTL1)
         rd = gctl1_q;
      else if (avs_address == PIC_A_GCTL2)
         rd = gctl2_q;
      else if (avs_address == PIC_A_FLAG0 || avs_address == PIC_A_FLAG0 + 5'h1)
         rd = avs_address[0] ? flag_q[31:16] : flag_q[15:0];
      else if (avs_address == PIC_A_EN0 || avs_address == PIC_A_EN0 + 5'h1)
         rd = avs_address[0] ? en_q[31:16] : en_q[15:0];
      else if (avs_address >= PIC_A_PRI0 && avs_address < PIC_A_VEC)
      begin
         for (int k = 0; k < 4; k++)
            rd[k*4 +: 3] = pri_q[(avs_address - PIC_A_PRI0) * 4 + k];
      end
      else if (avs_address == PIC_A_VEC)
         rd = {4'h0, lvl_q, 1'b0, vec_q};
      else if (avs_address == PIC_A_SR)
         rd = {8'h00, ipl_low_q, 5'h00};
      else if (avs_address == PIC_A_CORE)
         rd = {12'h000, cpu_priority_top_bit_q, 3'h0};
      else if (avs_address == PIC_A_IRQST)
         rd = {11'h000, irq_st_q};
      else if (avs_address == PIC_A_IRQEN)
         rd = {11'h000, irq_en_q};
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         rdata_q <= 32'h0;
      else if (acc && avs_read)
         rdata_q <= (avs_address > PIC_A_IRQCLR) ? PIC_UNMAPPED : {16'h0000, rd};
   end
   assign avs_readdata = rdata_q;
endmodule

// ---- testbench/pic_core_model.sv ----
// Purpose: behavioural processor core that takes pending requests
// Assumes: cpu_irq is a registered level from the controller
// Notes: ack_wait sets how slowly the core answers, ack_on lets it answer at all
`timescale 1ns/1ps
module pic_core_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cpu_irq,
   input wire logic ack_on,
   input wire logic [3:0] ack_wait,
   output logic cpu_ack
);
   logic [3:0] wait_q;
   // count cycles of a pending request, then give a one-cycle acceptance
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_q <= 4'h0;
         cpu_ack <= 1'b0;
      end
      else
      begin
         cpu_ack <= cpu_irq && ack_on && !cpu_ack && wait_q == ack_wait;
         wait_q <= (cpu_irq && ack_on && !cpu_ack) ? wait_q + 4'h1 : 4'h0;
      end
   end
endmodule

// ---- testbench/pic_ctrl_properties.sv ----
// Purpose: port checker for the interrupt controller
// Assumes: one clock, async active-low reset
// Notes: bound to every controller instance
`timescale 1ns/1ps
module pic_ctrl_chk
   import pic_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [31:0] avs_readdata,
   input wire logic cpu_irq,
   input wire logic cpu_trap,
   input wire logic [6:0] pending_vector_number,
   input wire logic [3:0] pending_level
);
   // all checks share the one clock and its reset
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wait_first_a: assert property ($rose(avs_read) |-> avs_waitrequest)
      else $error("read not stalled in its first cycle");
   wait_release_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   unmapped_read_a: assert property (avs_read && !avs_waitrequest && avs_address > 5'h14
      |-> avs_readdata == PIC_UNMAPPED)
      else $error("unmapped read value wrong");
   reset_quiet_a: assert property ($rose(rst_n) |-> !cpu_irq && pending_level == 4'h0)
      else $error("request out of reset");
   irq_level_a: assert property (cpu_irq |-> pending_level != 4'h0)
      else $error("request with level zero");
   trap_vector_a: assert property (cpu_irq && cpu_trap
      |-> pending_level == 4'hf && pending_vector_number == 7'h00)
      else $error("trap vector or level wrong");
   user_level_a: assert property (cpu_irq && !cpu_trap |-> pending_level inside {[4'h1:4'h7]})
      else $error("user level out of range");
   user_vector_a: assert property (cpu_irq && !cpu_trap
      |-> pending_vector_number inside {[PIC_VEC_BASE:7'h27]})
      else $error("user vector out of range");
endmodule
bind pic_ctrl pic_ctrl_chk pic_ctrl_chk_i (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
   .avs_waitrequest, .avs_readdata, .cpu_irq, .cpu_trap, .pending_vector_number, .pending_level);

// ---- testbench/pic_ctrl_tb_top.sv ----
// Purpose: self-checking bench for the interrupt controller
// Assumes: one-cycle bus answer, source pulses one cycle wide
// Notes: byte enables and external pins are held constant
`timescale 1ns/1ps
module pic_ctrl_tb_top;
   import pic_pkg::*;
   logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, cpu_ack, cpu_irq, cpu_trap, irq, ack_on;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [PIC_NSRC-1:0] src_req;
   logic [PIC_NTRAP-1:0] trap_req;
   logic [6:0] pending_vector_number;
   logic [3:0] pending_level;
   int bad_count, cmp_count;
   pic_ctrl pic_ctrl_i (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'h3), .avs_readdata, .avs_waitrequest, .src_req, .ext_req(3'h0), .trap_req,
      .cpu_ack, .cpu_irq, .cpu_trap, .pending_vector_number, .pending_level, .irq);
   pic_core_model pic_core_model_i (.clk_sys, .rst_n, .cpu_irq, .ack_on, .ack_wait(4'h3), .cpu_ack);
   // 40 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         bad_count++;
      end
   endtask
   // request held until waitrequest is seen low, read data taken at that edge
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 40);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (n >= 40)
      begin
         chk("bus answer", 32'h0, 32'h1);
         stop_test();
      end
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      bus(1'b1, a, {16'h0, d});
   endtask
   task automatic pulse(input logic [PIC_NSRC-1:0] s, input logic [PIC_NTRAP-1:0] t);
      @(posedge clk_sys);
      src_req <= s;
      trap_req <= t;
      @(posedge clk_sys);
      src_req <= '0;
      trap_req <= '0;
   endtask
   // bounded wait for a request line to reach a level
   task automatic see(input logic sel, input logic v, input string nm);
      int n;
      n = 0;
      while ((sel ? irq : cpu_irq) !== v && n < 20)
      begin
         @(negedge clk_sys);
         n++;
      end
      chk(nm, {31'h0, v}, {31'h0, sel ? irq : cpu_irq});
   endtask
   // latency is two cycles, so four cycles of silence means refused
   task automatic quiet(input logic sel, input string nm);
      repeat (4) @(negedge clk_sys);
      chk(nm, 32'h0, {31'h0, sel ? irq : cpu_irq});
   endtask
   task automatic t_reset();
      rd(PIC_A_VEC, 32'h0, "vector after reset");
      rd(PIC_A_SR, 32'h0, "status after reset");
      rd(PIC_A_CORE, 32'h0, "core after reset");
      rd(PIC_A_FLAG0, 32'h0, "flags after reset");
      rd(PIC_A_EN0, 32'h0, "enables after reset");
      rd(5'h1f, PIC_UNMAPPED, "unmapped read");
      $display("test reset done");
   endtask
   task automatic t_vec();
      wr(PIC_A_EN0, 16'h0003);
      wr(PIC_A_PRI0, 16'h0025);
      pulse(32'h1, 5'h0);
      see(1'b0, 1'b1, "request raised");
      chk("vector", 32'h8, {25'h0, pending_vector_number});
      chk("level", 32'h5, {28'h0, pending_level});
      rd(PIC_A_FLAG0, 32'h1, "flag set");
      wr(PIC_A_FLAG0, 16'h0000);
      rd(PIC_A_FLAG0, 32'h0, "flag cleared");
      see(1'b0, 1'b0, "request gone");
      wr(PIC_A_PRI0, 16'h0033);
      pulse(32'h3, 5'h0);
      see(1'b0, 1'b1, "tie raised");
      rd(PIC_A_VEC, 32'h0308, "tie vector register");
      wr(PIC_A_EN0, 16'h0002);
      wr(PIC_A_FLAG0, 16'h0000);
      pulse(32'h1, 5'h0);
      quiet(1'b0, "disabled source held");
      rd(PIC_A_FLAG0, 32'h1, "disabled flag set");
      $display("test vector done");
   endtask
   task automatic t_mask();
      wr(PIC_A_FLAG0, 16'h0000);
      wr(PIC_A_EN0, 16'h0003);
      wr(PIC_A_PRI0, 16'h0075);
      wr(PIC_A_SR, 16'h00a0);
      rd(PIC_A_SR, 32'h00a0, "status level");
      pulse(32'h1, 5'h0);
      quiet(1'b0, "equal level held");
      pulse(32'h2, 5'h0);
      see(1'b0, 1'b1, "higher level raised");
      chk("masked vector", 32'h9, {25'h0, pending_vector_number});
      wr(PIC_A_SR, 16'h00e0);
      see(1'b0, 1'b0, "level seven blocks");
      wr(PIC_A_GCTL1, 16'h8000);
      rd(PIC_A_GCTL1, 32'h8000, "nesting bit");
      wr(PIC_A_SR, 16'h0000);
      rd(PIC_A_SR, 32'h00e0, "status locked");
      wr(PIC_A_GCTL1, 16'h0000);
      wr(PIC_A_CORE, 16'h0008);
      rd(PIC_A_CORE, 32'h0, "top bit refused");
      $display("test mask done");
   endtask
   task automatic t_irq();
      wr(PIC_A_FLAG0, 16'h0000);
      wr(PIC_A_SR, 16'h0000);
      wr(PIC_A_IRQCLR, 16'h001f);
      wr(PIC_A_IRQEN, 16'h0002);
      quiet(1'b1, "event line idle");
      pulse(32'h1, 5'h0);
      see(1'b1, 1'b1, "event line raised");
      wr(PIC_A_IRQCLR, 16'h0002);
      see(1'b1, 1'b0, "event line cleared");
      wr(PIC_A_IRQEN, 16'h0000);
      pulse(32'h1, 5'h0);
      quiet(1'b1, "event line masked");
      $display("test event line done");
   endtask
   task automatic t_trap();
      wr(PIC_A_SR, 16'h00e0);
      pulse(32'h0, 5'h01);
      see(1'b0, 1'b1, "trap through level seven");
      chk("trap level", 32'hf, {28'h0, pending_level});
      chk("trap mark", 32'h1, {31'h0, cpu_trap});
      rd(PIC_A_GCTL1, 32'h0002, "trap flag");
      ack_on <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rd(PIC_A_CORE, 32'h0008, "top bit after trap");
      $display("test trap done");
   endtask
   // reset, then the scenarios in order
   initial
   begin
      rst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 5'h0;
      avs_writedata = 32'h0;
      src_req = '0;
      trap_req = '0;
      ack_on = 1'b0;
      bad_count = 0;
      cmp_count = 0;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset();
      t_vec();
      t_mask();
      t_irq();
      t_trap();
      stop_test();
   end
endmodule
